/* common/bvs_pkg.sv */
// Package with constants and carrier types for the bus voltage supervisor.
package bvs_pkg;
    localparam int CLK_MHZ = 100;
    localparam int MS_TIME = 1;
    localparam int CYC_PER_MS = MS_TIME * CLK_MHZ * 1000;
    localparam int SEC_TIME = 1000;
    localparam int CYC_PER_SEC = SEC_TIME * CYC_PER_MS;
    localparam int OV_WAIT_MS = 50;
    localparam int CB_PULSE_MS = 1;
    localparam int DETECT_MS = 1;
    localparam int RECOVER_MS = 1000;
    localparam int SAVE_PERIOD_S = 3600;
    localparam int ADC_W = 10;
    localparam int CNT_W = 32;
    localparam int NGRP = 4;
    localparam int NAUX = 4;
    localparam logic [9:0] UV_THR_RST = 10'h2E8;
    localparam logic [9:0] OV_THR_RST = 10'h38C;
    localparam logic [9:0] HYST_RST = 10'h008;

    typedef struct packed {
        logic [ADC_W-1:0] uv_thr;
        logic [ADC_W-1:0] ov_thr;
        logic [ADC_W-1:0] hyst;
        logic auto_on;
        logic fe_auto_on;
        logic ref_ext;
    } bvs_cfg_t;

    typedef struct packed {
        logic bus_low_flag;
        logic bus_high_flag;
        logic [NAUX-1:0] aux_status;
        logic [ADC_W-1:0] bus_code;
        logic [CNT_W-1:0] uptime;
    } bvs_stat_t;

    typedef enum logic [2:0] {
        ST_RUN = 3'b000,
        ST_UV_OFF = 3'b001,
        ST_OV_WAIT = 3'b010,
        ST_OV_FE_OFF = 3'b011,
        ST_OV_RECOVER = 3'b100,
        ST_REPROG = 3'b101
    } bvs_state_t;
endpackage

/* design/bvs_uptime.sv */
// Uptime counter with one-second tick and periodic backup.
`timescale 1ns/1ps
module bvs_uptime
    import bvs_pkg::*;
#(
    parameter int TICK_CYC = CYC_PER_SEC,
    parameter int SAVE_SEC = SAVE_PERIOD_S
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic load,
    input wire logic [CNT_W-1:0] load_value,
    input wire logic save_req,
    output logic [CNT_W-1:0] count,
    output logic save_pulse
);
    initial begin
        if (TICK_CYC < 2 || SAVE_SEC < 1) begin
            $error("bvs_uptime: bad timing parameters");
        end
    end

    logic [31:0] tick_cnt;
    logic [31:0] next_tick_cnt;
    logic [31:0] sec_cnt;
    logic [31:0] next_sec_cnt;
    logic [CNT_W-1:0] next_count;
    logic next_save_pulse;

    always_comb begin
        next_tick_cnt = tick_cnt + 32'h1;
        next_sec_cnt = sec_cnt;
        next_count = count;
        next_save_pulse = save_req;
        if (tick_cnt == 32'(TICK_CYC - 1)) begin
            next_tick_cnt = '0;
            next_count = count + 32'h1;
            next_sec_cnt = sec_cnt + 32'h1;
            if (sec_cnt == 32'(SAVE_SEC - 1)) begin
                next_sec_cnt = '0;
                next_save_pulse = 1'b1;
            end
        end
        if (load) begin
            next_count = load_value;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            tick_cnt <= '0;
            sec_cnt <= '0;
            count <= '0;
            save_pulse <= 1'b0;
        end else begin
            tick_cnt <= next_tick_cnt;
            sec_cnt <= next_sec_cnt;
            count <= next_count;
            save_pulse <= next_save_pulse;
        end
    end

    a_tick_counts: assert property (@(posedge clk) disable iff (!reset_n)
        (tick_cnt == 32'(TICK_CYC - 1) && !load) |=> count == $past(count) + 1)
        else $error("uptime did not advance on tick");
endmodule

/* design/bvs_compare.sv */
// Four threshold crossing comparisons with hysteresis.
`timescale 1ns/1ps
module bvs_compare
    import bvs_pkg::*;
(
    input wire logic [ADC_W-1:0] code,
    input wire logic [ADC_W-1:0] uv_thr,
    input wire logic [ADC_W-1:0] ov_thr,
    input wire logic [ADC_W-1:0] hyst,
    output logic uv_fall,
    output logic uv_rise,
    output logic ov_rise,
    output logic ov_fall
);
    // One extra bit keeps code or threshold plus hysteresis from wrapping.
    logic [ADC_W:0] c;
    always_comb begin
        c = {1'b0, code};
        uv_fall = (c + {1'b0, hyst}) < {1'b0, uv_thr};
        uv_rise = c > ({1'b0, uv_thr} + {1'b0, hyst});
        ov_rise = c > ({1'b0, ov_thr} + {1'b0, hyst});
        ov_fall = (c + {1'b0, hyst}) < {1'b0, ov_thr};
    end
endmodule

/* design/bvs_top.sv */
// Bus voltage supervisor: aux status, uptime, bus voltage protection.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module bvs_top
    import bvs_pkg::*;
#(
    parameter int DETECT_CYC = DETECT_MS * CYC_PER_MS,
    parameter int OV_WAIT_CYC = OV_WAIT_MS * CYC_PER_MS,
    parameter int CB_CYC = CB_PULSE_MS * CYC_PER_MS,
    parameter int RECOVER_CYC = RECOVER_MS * CYC_PER_MS,
    parameter int TICK_CYC = CYC_PER_SEC,
    parameter int SAVE_SEC = SAVE_PERIOD_S
) (
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic [NAUX-1:0] AUX_GOOD_INPUTS,
    input wire logic [ADC_W-1:0] BUS_CODE,
    input wire logic BUS_CODE_VALID,
    input wire bvs_cfg_t CFG,
    input wire logic [CNT_W-1:0] NV_UPTIME,
    input wire logic FE_ON_CMD,
    input wire logic TURN_ON_CMD,
    input wire logic PROG_DONE,
    input wire logic [NGRP-1:0] GROUP_FAULT_IN,
    output logic [NGRP-1:0] GROUP_FAULT_OE,
    output logic [NGRP-1:0] GROUP_FAULT_OUT,
    output logic FRONT_END_ENABLE,
    output logic CROWBAR_TRIGGER,
    output logic REF_EXT_SEL,
    output logic PROG_STATUS_CLEAR,
    output logic REPROG_START,
    output logic TURN_ON,
    output logic NV_SAVE,
    output bvs_stat_t STATUS
);
    initial begin
        if (DETECT_CYC < 1 || OV_WAIT_CYC <= DETECT_CYC || CB_CYC < 1 ||
            RECOVER_CYC < 1) begin
            $error("bvs_top: bad timing parameters");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers; the first stage feeds only the second.
    logic [NAUX-1:0] aux_s1;
    logic [NAUX-1:0] aux_s2;
    logic [NGRP-1:0] grp_s1;
    logic [NGRP-1:0] grp_s2;
    logic [NAUX-1:0] aux_status;
    logic [NAUX-1:0] next_aux_status;
    logic [ADC_W-1:0] bus_code;
    logic [ADC_W-1:0] next_bus_code;
    logic code_new;

    always_comb begin
        next_aux_status = aux_s2;
        next_bus_code = BUS_CODE_VALID ? BUS_CODE : bus_code;
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            aux_s1 <= '1;
            aux_s2 <= '1;
            grp_s1 <= '1;
            grp_s2 <= '1;
            aux_status <= '1;
            bus_code <= '0;
            code_new <= 1'b0;
        end else begin
            aux_s1 <= AUX_GOOD_INPUTS;
            aux_s2 <= aux_s1;
            grp_s1 <= GROUP_FAULT_IN;
            grp_s2 <= grp_s1;
            aux_status <= next_aux_status;
            bus_code <= next_bus_code;
            code_new <= BUS_CODE_VALID;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset-captured configuration and power-up load.
    logic ref_ext;
    logic next_ref_ext;
    logic boot;
    logic boot_done;
    logic fe_cmd_seen;

    always_comb begin
        next_ref_ext = boot ? CFG.ref_ext : ref_ext;
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            ref_ext <= 1'b0;
            boot <= 1'b1;
            boot_done <= 1'b0;
        end else begin
            ref_ext <= next_ref_ext;
            boot <= 1'b0;
            boot_done <= boot_done | boot;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Uptime and comparisons.
    logic [CNT_W-1:0] uptime;
    logic periodic_save;
    logic event_save;
    logic uv_fall;
    logic uv_rise;
    logic ov_rise;
    logic ov_fall;

    bvs_uptime #(
        .TICK_CYC(TICK_CYC),
        .SAVE_SEC(SAVE_SEC)
    ) u_uptime (
        .clk(CORE_CLK),
        .reset_n(RESET_N),
        .load(boot),
        .load_value(NV_UPTIME),
        .save_req(event_save),
        .count(uptime),
        .save_pulse(periodic_save)
    );

    bvs_compare u_compare (
        .code(bus_code),
        .uv_thr(CFG.uv_thr),
        .ov_thr(CFG.ov_thr),
        .hyst(CFG.hyst),
        .uv_fall(uv_fall),
        .uv_rise(uv_rise),
        .ov_rise(ov_rise),
        .ov_fall(ov_fall)
    );

    ////////////////////////////////////////////////////////////////////////
    // Protection sequencer.
    bvs_state_t state;
    bvs_state_t next_state;
    logic [31:0] timer;
    logic [31:0] next_timer;
    logic [31:0] det_cnt;
    logic [31:0] next_det_cnt;
    logic [31:0] cb_cnt;
    logic [31:0] next_cb_cnt;
    logic faults_low;
    logic next_faults_low;
    logic front_end_enable;
    logic next_front_end_enable;
    logic cb_done;
    logic next_cb_done;
    logic low_flag;
    logic next_low_flag;
    logic high_flag;
    logic next_high_flag;
    logic next_fe_cmd_seen;
    logic pend_uv;
    logic pend_ov;

    // Entry crossings (uv_fall in ST_RUN, ov_rise in ST_RUN or ST_UV_OFF) are only acted on
    // after the filter delay, as converter noise would otherwise chatter the group fault lines.
    assign pend_uv = (state == ST_RUN) && uv_fall;
    assign pend_ov = (state == ST_RUN || state == ST_UV_OFF) && ov_rise;

    always_comb begin
        next_state = state;
        next_timer = timer;
        next_det_cnt = '0;
        next_cb_cnt = (cb_cnt != 32'h0) ? cb_cnt - 32'h1 : 32'h0;
        next_faults_low = faults_low;
        next_front_end_enable = front_end_enable;
        next_cb_done = cb_done;
        next_low_flag = low_flag;
        next_high_flag = high_flag;
        next_fe_cmd_seen = fe_cmd_seen | FE_ON_CMD;
        event_save = 1'b0;
        PROG_STATUS_CLEAR = 1'b0;
        REPROG_START = 1'b0;
        TURN_ON = 1'b0;
        if (boot) begin
            next_front_end_enable = CFG.fe_auto_on;
        end else if (FE_ON_CMD && state != ST_OV_FE_OFF) begin
            next_front_end_enable = 1'b1;
        end
        if (pend_uv || pend_ov) begin
            next_det_cnt = det_cnt + 32'h1;
        end
        case (state)
            ST_RUN: begin
                if (TURN_ON_CMD) begin
                    TURN_ON = 1'b1;
                end
                if (det_cnt == 32'(DETECT_CYC - 1) && pend_ov) begin
                    next_det_cnt = '0;
                    next_faults_low = 1'b1;
                    event_save = 1'b1;
                    next_timer = 32'(OV_WAIT_CYC - DETECT_CYC);
                    next_state = ST_OV_WAIT;
                end else if (det_cnt == 32'(DETECT_CYC - 1) && pend_uv) begin
                    next_det_cnt = '0;
                    next_faults_low = 1'b1;
                    event_save = 1'b1;
                    PROG_STATUS_CLEAR = 1'b1;
                    next_low_flag = 1'b1;
                    next_state = ST_UV_OFF;
                end
            end
            ST_UV_OFF: begin
                if (det_cnt == 32'(DETECT_CYC - 1) && pend_ov) begin
                    next_det_cnt = '0;
                    event_save = 1'b1;
                    next_timer = 32'(OV_WAIT_CYC - DETECT_CYC);
                    next_state = ST_OV_WAIT;
                end else if (uv_rise) begin
                    next_low_flag = 1'b0;
                    REPROG_START = 1'b1;
                    next_state = ST_REPROG;
                end
            end
            ST_OV_WAIT: begin
                if (ov_fall) begin
                    next_timer = 32'(RECOVER_CYC - 1);
                    next_state = ST_OV_RECOVER;
                end else if (timer <= 32'h1) begin
                    next_front_end_enable = 1'b0;
                    PROG_STATUS_CLEAR = 1'b1;
                    next_high_flag = 1'b1;
                    next_cb_done = 1'b0;
                    next_timer = 32'(OV_WAIT_CYC - 1);
                    next_state = ST_OV_FE_OFF;
                end else begin
                    next_timer = timer - 32'h1;
                end
            end
            ST_OV_FE_OFF: begin
                next_front_end_enable = 1'b0;
                if (ov_fall) begin
                    next_high_flag = 1'b0;
                    next_timer = 32'(RECOVER_CYC - 1);
                    next_state = ST_OV_RECOVER;
                end else if (timer != 32'h0) begin
                    next_timer = timer - 32'h1;
                end else if (!cb_done) begin
                    next_cb_cnt = 32'(CB_CYC);
                    next_cb_done = 1'b1;
                end
            end
            ST_OV_RECOVER: begin
                if (ov_rise) begin
                    next_timer = 32'(OV_WAIT_CYC - 1);
                    next_state = ST_OV_WAIT;
                end else if (timer == 32'h0) begin
                    next_front_end_enable = 1'b1;
                    next_high_flag = 1'b0;
                    REPROG_START = 1'b1;
                    next_state = ST_REPROG;
                end else begin
                    next_timer = timer - 32'h1;
                end
            end
            ST_REPROG: begin
                if (PROG_DONE) begin
                    next_faults_low = 1'b0;
                    TURN_ON = CFG.auto_on;
                    next_state = ST_RUN;
                end
            end
            default: begin
                next_state = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            state <= ST_RUN;
            timer <= '0;
            det_cnt <= '0;
            cb_cnt <= '0;
            faults_low <= 1'b0;
            front_end_enable <= 1'b0;
            cb_done <= 1'b0;
            low_flag <= 1'b0;
            high_flag <= 1'b0;
            fe_cmd_seen <= 1'b0;
        end else begin
            state <= next_state;
            timer <= next_timer;
            det_cnt <= next_det_cnt;
            cb_cnt <= next_cb_cnt;
            faults_low <= next_faults_low;
            front_end_enable <= next_front_end_enable;
            cb_done <= next_cb_done;
            low_flag <= next_low_flag;
            high_flag <= next_high_flag;
            fe_cmd_seen <= next_fe_cmd_seen;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs. Fault lines are open drain: driven only while pulled low.
    always_comb begin
        GROUP_FAULT_OE = {NGRP{faults_low}};
        GROUP_FAULT_OUT = '0;
        FRONT_END_ENABLE = front_end_enable;
        CROWBAR_TRIGGER = (cb_cnt != 32'h0);
        REF_EXT_SEL = ref_ext;
        NV_SAVE = periodic_save;
        STATUS.bus_low_flag = low_flag;
        STATUS.bus_high_flag = high_flag;
        STATUS.aux_status = aux_status;
        STATUS.bus_code = bus_code;
        STATUS.uptime = uptime;
    end

    ////////////////////////////////////////////////////////////////////////
    sequence s_ov_enter;
        state == ST_RUN ##1 state == ST_OV_WAIT;
    endsequence

    a_uv_drops_lines: assert property (@(posedge CORE_CLK) disable iff
        (!RESET_N) (state == ST_RUN && next_state == ST_UV_OFF)
        |=> faults_low && low_flag) else $error("uv did not drop lines");
    a_uv_clears_prog: assert property (@(posedge CORE_CLK) disable iff
        (!RESET_N) (state == ST_RUN && next_state == ST_UV_OFF)
        |-> PROG_STATUS_CLEAR && event_save) else $error("uv no clear");
    a_ov_save: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        s_ov_enter |-> faults_low && $past(event_save))
        else $error("ov entry without save");
    a_fe_drop: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        (state == ST_OV_WAIT && next_state == ST_OV_FE_OFF)
        |=> !front_end_enable && high_flag) else $error("fe not dropped");
    a_cb_pulse: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        $rose(CROWBAR_TRIGGER) |-> cb_cnt == 32'(CB_CYC))
        else $error("crowbar pulse length wrong");
    a_recover_fe: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        (state == ST_OV_RECOVER && next_state == ST_REPROG)
        |=> front_end_enable && state == ST_REPROG) else $error("fe not restored");
    a_auto_on: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        (state == ST_REPROG && PROG_DONE) |-> TURN_ON == CFG.auto_on)
        else $error("turn on mismatch");
    a_ref_hold: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        !boot |=> ref_ext == $past(ref_ext))
        else $error("reference changed without reset");
endmodule

/* bench/bvs_partner.sv */
// Behavioural model of the load converters behind the group fault lines.
`timescale 1ns/1ps
module bvs_partner
    import bvs_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] dly,
    input wire logic [NGRP-1:0] oe,
    input wire logic reprog_start,
    input wire logic turn_on,
    output logic [NGRP-1:0] line,
    output logic prog_done
);
    logic [NGRP-1:0] pwr;
    logic [7:0] cnt;
////////////////////////////////////////////////////////////////////////
    // Each line has a pull-up and is shared by a whole group.
    assign line = ~oe;
    always @(posedge clk) begin
        if (!reset_n) begin
            pwr <= '0;
            cnt <= 8'h00;
            prog_done <= 1'b0;
        end else begin
            // A slow answer only delays completion, never skips it.
            prog_done <= (cnt == 8'h01);
            if (reprog_start === 1'b1)
                cnt <= dly;
            else if (cnt != 8'h00)
                cnt <= cnt - 8'h01;
            // A low line turns the converters off unconditionally.
            pwr <= (pwr | {NGRP{turn_on}}) & line;
        end
    end
endmodule

/* bench/bvs_top_bench.sv */
// Self-checking bench for the bus voltage supervisor top level.
`timescale 1ns/1ps
module bvs_top_bench;
    import bvs_pkg::*;
    localparam int DT = 2;
    localparam int OW = 20;
    localparam int CB = 3;
    localparam int RC = 30;
    localparam int TK = 10;
    localparam int SV = 40;
    logic clk, rst_n, vld, fe_cmd, on_cmd, done, fe, cb, refx, clr, rp;
    logic ton, sv;
    logic [3:0] aux, fin, oe, cv[8], pv[8];
    logic [3:0] eq[8][$];
    logic [9:0] code, v;
    logic [31:0] nv, r;
    logic [7:0] dly;
    bvs_cfg_t cfg;
    bvs_stat_t st;
    int n_mismatch = 0;
    int n_compared = 0;
    int seed, cyc, nsv, lsv, cbw, toe, tfe, tcb, t0, n0;

    bvs_top #(.DETECT_CYC(DT), .OV_WAIT_CYC(OW), .CB_CYC(CB),
        .RECOVER_CYC(RC), .TICK_CYC(TK), .SAVE_SEC(SV)) bvs_top_i (
        .CORE_CLK(clk), .RESET_N(rst_n), .AUX_GOOD_INPUTS(aux),
        .BUS_CODE(code), .BUS_CODE_VALID(vld), .CFG(cfg),
        .NV_UPTIME(nv), .FE_ON_CMD(fe_cmd), .TURN_ON_CMD(on_cmd),
        .PROG_DONE(done), .GROUP_FAULT_IN(fin), .GROUP_FAULT_OE(oe),
        .GROUP_FAULT_OUT(), .FRONT_END_ENABLE(fe), .CROWBAR_TRIGGER(cb),
        .REF_EXT_SEL(refx), .PROG_STATUS_CLEAR(clr), .REPROG_START(rp),
        .TURN_ON(ton), .NV_SAVE(sv), .STATUS(st));
    bvs_partner bvs_partner_i (.clk(clk), .reset_n(rst_n), .dly(dly),
        .oe(oe), .reprog_start(rp), .turn_on(ton), .line(fin),
        .prog_done(done));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t: seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic tmo();
        n_mismatch++;
        $display("[ERR] %0t: wait ran out", $time);
        close_out();
    endtask
    function automatic int pend();
        int s;
        s = 0;
        foreach (eq[k]) s += eq[k].size();
        return s;
    endfunction
    function automatic logic inr(input int x, input int lo, input int hi);
        return x >= lo && x <= hi;
    endfunction
    task automatic ex(input int k, input logic [3:0] x);
        eq[k].push_back(x);
    endtask
    task automatic drain(input int lim);
        int n;
        n = 0;
        while (pend() != 0 && n < lim) begin
            @(posedge clk);
            n++;
        end
        if (pend() != 0)
            tmo();
        @(negedge clk);
    endtask
    task automatic put(input logic [9:0] x);
        @(posedge clk);
        code <= x;
    endtask
    // A code sitting exactly on a band edge must not trip anything.
    task automatic hold(input logic [9:0] x);
        put(x);
        repeat (DT + 8) @(negedge clk);
    endtask
    task automatic pulse(input logic w);
        @(posedge clk);
        fe_cmd <= w;
        on_cmd <= ~w;
        @(posedge clk);
        fe_cmd <= 1'b0;
        on_cmd <= 1'b0;
    endtask
    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        @(negedge clk);
    endtask
    task automatic wsave();
        int n;
        n = nsv;
        for (int i = 0; i < SV * TK + 20 && nsv == n; i++) @(negedge clk);
        if (nsv == n)
            tmo();
    endtask
    task automatic uv_trip();
        hold(UV_THR_RST - HYST_RST);
        n0 = nsv;
        ex(0, 4'hF);
        ex(3, 4'h1);
        ex(6, 4'h1);
        put(UV_THR_RST - HYST_RST - 10'h001);
        t0 = cyc;
        drain(DT + 10);
        chk(inr(toe - t0, DT, DT + 4), 1'b1);
        chk(nsv > n0, 1'b1);
    endtask
    task automatic recover(input logic [9:0] b, input logic [9:0] nb,
        input int k, input int lim);
        hold(b);
        ex(k, 4'h0);
        ex(4, 4'h1);
        ex(0, 4'h0);
        if (k == 7)
            ex(1, 4'h1);
        if (cfg.auto_on === 1'b1)
            ex(5, 4'h1);
        put(nb);
        t0 = cyc;
        drain(lim);
    endtask
////////////////////////////////////////////////////////////////////////
    // Events are matched per kind, so only their order within a kind counts.
    always @(negedge clk) begin
        cyc++;
        cv = '{oe, fe, cb, clr, rp, ton, st.bus_low_flag, st.bus_high_flag};
        if (!rst_n)
            pv = cv;
        if (sv === 1'b1) begin
            nsv++;
            lsv = cyc;
        end
        if (cb === 1'b1)
            cbw++;
        if (pv[0] !== cv[0])
            toe = cyc;
        if (pv[1] !== cv[1])
            tfe = cyc;
        if (pv[2] !== cv[2] && cv[2] === 4'h1)
            tcb = cyc;
        if (pv[2] === 4'h1 && cv[2] === 4'h0)
            chk(cbw, CB);
        for (int k = 0; k < 8; k++) begin
            if (cv[k] !== pv[k] && (k < 3 || k > 5 || cv[k] !== 4'h0))
                chk(cv[k], eq[k].size() ? eq[k].pop_front() : ~cv[k]);
        end
        pv = cv;
    end

    initial begin
        seed = 1312;
        rst_n = 1'b0;
        vld = 1'b1;
        fe_cmd = 1'b0;
        on_cmd = 1'b0;
        aux = 4'hF;
        code = 10'h300;
        nv = 32'hFFFF_FFFE;
        dly = 8'h01;
        cfg = '{UV_THR_RST, OV_THR_RST, HYST_RST, 1'b1, 1'b0, 1'b0};
        do_reset();
        chk(st.uptime, 32'hFFFF_FFFE);
        chk(fe, 1'b0);
        chk(refx, 1'b0);
        repeat (2 * TK) @(negedge clk);
        chk(st.uptime, 32'h0);
        ex(1, 4'h1);
        pulse(1'b1);
        drain(10);
        @(posedge clk);
        cfg.ref_ext <= 1'b1;
        cfg.fe_auto_on <= 1'b1;
        repeat (5) @(negedge clk);
        chk(refx, 1'b0);
        ex(1, 4'h1);
        do_reset();
        chk(refx, 1'b1);
        drain(5);
        $display("step reset finished");
        for (int i = 0; i < 6; i++) begin
            r = $random(seed);
            v = UV_THR_RST + HYST_RST + 10'h001 + {3'h0, r[14:8]};
            @(posedge clk);
            aux <= r[3:0];
            put(v);
            repeat (4) @(negedge clk);
            chk(st.aux_status, r[3:0]);
            chk(st.bus_code, v);
        end
        wsave();
        n0 = lsv;
        wsave();
        chk(lsv - n0, SV * TK);
        $display("step status finished");
        uv_trip();
        recover(UV_THR_RST + HYST_RST, UV_THR_RST + HYST_RST + 10'h001,
            6, 40);
        $display("step undervoltage finished");
        @(posedge clk);
        dly <= 8'h19;
        hold(OV_THR_RST + HYST_RST);
        n0 = nsv;
        ex(0, 4'hF);
        ex(1, 4'h0);
        ex(3, 4'h1);
        ex(7, 4'h1);
        ex(2, 4'h1);
        ex(2, 4'h0);
        put(OV_THR_RST + HYST_RST + 10'h001);
        t0 = cyc;
        drain(2 * OW + 30);
        chk(inr(toe - t0, DT, DT + 4), 1'b1);
        chk(nsv > n0, 1'b1);
        chk(inr(tfe - t0, OW - 1, OW + 4), 1'b1);
        chk(inr(tcb - tfe, OW - 1, OW + 2), 1'b1);
        pulse(1'b1);
        repeat (OW + 5) @(negedge clk);
        recover(OV_THR_RST - HYST_RST, OV_THR_RST - HYST_RST - 10'h001,
            7, RC + 60);
        chk(inr(tfe - t0, RC - 1, RC + 4), 1'b1);
        $display("step overvoltage finished");
        @(posedge clk);
        cfg.auto_on <= 1'b0;
        dly <= 8'h01;
        uv_trip();
        recover(UV_THR_RST + HYST_RST, UV_THR_RST + HYST_RST + 10'h001,
            6, 40);
        repeat (5) @(negedge clk);
        ex(5, 4'h1);
        pulse(1'b0);
        drain(5);
        $display("step manual turn-on finished");
        chk(pend(), 0);
        close_out();
    end
endmodule
